// *** verilog/status_params.svh ***
/*
 Offsets, field positions and reset values of the global status register group.
 Assumes inclusion by bare name from the status package and modules.
*/
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH
`define OFS_GENERAL_INPUT_LEVELS 16'h0219
`define OFS_INTERRUPT_SUMMARY 16'h021A
`define OFS_RESERVED_STATUS_B 16'h021B
`define OFS_CALIBRATION_CODE_PLL0 16'h021C
`define OFS_CALIBRATION_CODE_PLL1 16'h021D
`define OFS_CONFIG_LOAD_FAILURE 16'h021E
`define OFS_CONFIG_LOAD_RESULT 16'h021F
`define GEN_INPUT_WIDTH 4
`define CAL_WIDTH 6
`define BIT_INT_SUMMARY 0
`define BIT_LOAD_FAILED 0
`define BIT_LOAD_DONE 0
`define BIT_CHECKSUM_OK 3
`define RST_LOAD_FLAGS 1'h0
`define RST_CHECKSUM_OK 1'h1
`define RST_READ_DATA 8'h00
`define RST_SYNC 3'h0
`endif

// *** verilog/status_pkg.sv ***
/*
 Types shared by the global status register group.
 Assumes the constants header is on the include path.
*/
`include "status_params.svh"
package status_pkg;
   // Register read request from the serial port engine
   typedef struct packed
   {
      logic rd;
      logic [15:0] addr;
   } reg_req_s;
   // Register read answer
   typedef struct packed
   {
      logic valid;
      logic hit;
      logic [7:0] data;
   } reg_rsp_s;
   // Events reported by the configuration loader
   typedef struct packed
   {
      logic done;
      logic failed;
      logic crc_error;
   } load_evt_s;
endpackage : status_pkg

// *** verilog/pin_sync.sv ***
/*
 Three-stage synchroniser with agreement filter for a vector of pin inputs.
 Assumes pins are asynchronous to clk.
*/
`timescale 1ns/100ps
module pin_sync
#(
   parameter int WIDTH = 4
)
(
   input wire logic clk, // Core clock
   input wire logic hardware_reset_low, // Asynchronous reset, active low
   input wire logic [WIDTH-1:0] pin_in, // Asynchronous pin levels
   output logic [WIDTH-1:0] level_q // Filtered level
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   genvar i;
   // Three synchroniser flops and an output flop per bit; a change counts when stages two and three agree
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always_ff @(posedge clk or negedge hardware_reset_low)
         begin
            if (!hardware_reset_low)
            begin
               s1_q[i] <= 1'b0;
               s2_q[i] <= 1'b0;
               s3_q[i] <= 1'b0;
               level_q[i] <= 1'b0;
            end
            else
            begin
               s1_q[i] <= pin_in[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i])
                  level_q[i] <= s3_q[i];
            end
         end
      end
   endgenerate
endmodule : pin_sync

// *** verilog/global_status_registers.sv ***
/*
 Global status register group: pin levels, interrupt summary, configuration
 load result and PLL calibration codes, read over the serial port engine.
 Assumes the serial engine presents one-cycle read strobes on clk, and the
 loader and interrupt logic drive their levels and pulses on clk.
 Register map, all read-only, reserved bits read as zero:
   0x219 bits 3:0  synchronised levels of pins set as inputs
   0x21A bit 0     interrupt summary, mirrored inverted on the pin
   0x21B           reserved, reads zero
   0x21C bits 5:0  PLL0 calibration code
   0x21D bits 5:0  PLL1 calibration code
   0x21E bit 0     load failed, sticky until reset
   0x21F bit 3     checksum good, low on a checksum error
   0x21F bit 0     load done, sticky until reset
 Timing: a read strobe at edge n is answered at edge n+1 for one cycle.
 Pin levels settle four edges after a stable pin change.
 The lockout output must be honoured by the serial engine; only the reset
 pin releases it, since no register write reaches this group.
*/
// Operation
// - Input-level register shows input-configured pin levels
// - Summary bit and low interrupt pin track enabled status
// - Load-failed flag sticks until device reset
// - Load-done flag sticks until device reset
// - Checksum flag low when EEPROM CRC fails
// - Checksum failure locks serial port until reset
// - Six-bit calibration code per PLL, read-only
`timescale 1ns/100ps
`include "status_params.svh"
module global_status_registers
   import status_pkg::*;
(
   input wire logic clk, // Core clock, 250 MHz
   input wire logic hardware_reset_low, // Asynchronous reset, active low
   input wire logic [`GEN_INPUT_WIDTH-1:0] gpio_pin_in, // Raw GPIO pin levels
   input wire logic [`GEN_INPUT_WIDTH-1:0] gpio_is_input, // Pin configured as input
   input wire logic [7:0] int_status, // Interrupt status bits
   input wire logic [7:0] int_enable, // Interrupt enables
   input wire load_evt_s load_evt, // Loader event pulses
   input wire logic [`CAL_WIDTH-1:0] calibration_code_0, // PLL0 calibration code
   input wire logic [`CAL_WIDTH-1:0] calibration_code_1, // PLL1 calibration code
   input wire reg_req_s req, // Register read request
   output reg_rsp_s rsp, // Register read answer
   output logic interrupt_request_low, // Interrupt pin, active low
   output logic serial_port_locked // Serial port lockout
);
   // Synchronised pin levels and the copy masked by the pin direction
   logic [`GEN_INPUT_WIDTH-1:0] general_input_level;
   logic [`GEN_INPUT_WIDTH-1:0] level_masked;
   // Per-bit enabled interrupt status and their summary
   logic [7:0] int_active;
   logic any_active;
   // Read strobe, and the strobe qualified by a mapped address
   logic rd_take;
   logic rd_take_hit;
   logic config_load_failed_q;
   logic config_load_done_q;
   logic config_checksum_ok_q;
   logic int_summary_q;
   logic [`CAL_WIDTH-1:0] cal0_q;
   logic [`CAL_WIDTH-1:0] cal1_q;
   logic rsp_valid_q;
   logic rsp_hit_q;
   logic [7:0] rsp_data_q;
   logic [7:0] rd_data;
   logic rd_hit;

   // Address decode into register read value
   function automatic logic [8:0] read_mux(input logic [15:0] a,
                                           input logic [`GEN_INPUT_WIDTH-1:0] lvl,
                                           input logic isum,
                                           input logic [`CAL_WIDTH-1:0] c0,
                                           input logic [`CAL_WIDTH-1:0] c1,
                                           input logic lfail,
                                           input logic ldone,
                                           input logic crcok);
      logic [7:0] d;
      logic h;
      d = 8'h00;
      h = 1'b1;
      unique case (a)
         `OFS_GENERAL_INPUT_LEVELS:
         begin
            // Only the four low bits carry pin levels
            d[`GEN_INPUT_WIDTH-1:0] = lvl;
         end
         `OFS_INTERRUPT_SUMMARY:
         begin
            // Summary alone in bit 0
            d[`BIT_INT_SUMMARY] = isum;
         end
         `OFS_RESERVED_STATUS_B:
         begin
            // Whole byte reserved
            d = 8'h00;
         end
         `OFS_CALIBRATION_CODE_PLL0:
         begin
            // Six-bit code, top bits reserved
            d[`CAL_WIDTH-1:0] = c0;
         end
         `OFS_CALIBRATION_CODE_PLL1:
         begin
            // Six-bit code, top bits reserved
            d[`CAL_WIDTH-1:0] = c1;
         end
         `OFS_CONFIG_LOAD_FAILURE:
         begin
            // Failure flag alone in bit 0
            d[`BIT_LOAD_FAILED] = lfail;
         end
         `OFS_CONFIG_LOAD_RESULT:
         begin
            d[`BIT_LOAD_DONE] = ldone;
            d[`BIT_CHECKSUM_OK] = crcok;
         end
         default: h = 1'b0;
      endcase
      return {h, d};
   endfunction : read_mux

   // Pin levels synchronised, masked to input-configured pins
   pin_sync #(.WIDTH(`GEN_INPUT_WIDTH)) u_level_sync
   (
      .clk(clk),
      .hardware_reset_low(hardware_reset_low),
      .pin_in(gpio_pin_in),
      .level_q(general_input_level)
   );

   // Per-pin direction mask: pins set as outputs read back as zero
   generate
      for (genvar p = 0; p < `GEN_INPUT_WIDTH; p = p + 1)
      begin : g_level_mask
         assign level_masked[p] = general_input_level[p] & gpio_is_input[p];
      end
   endgenerate

   // Per-bit enable mask of the interrupt status
   generate
      for (genvar b = 0; b < 8; b = b + 1)
      begin : g_int_active
         assign int_active[b] = int_status[b] & int_enable[b];
      end
   endgenerate

   // Any enabled status bit raises the summary
   assign any_active = |int_active;

   // Interrupt summary from enabled status bits
   // Registering keeps glitches of the status logic off the pin
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
         int_summary_q <= 1'b0;
      else
         int_summary_q <= any_active;
   end

   // Pin is low while summary is set, released otherwise
   assign interrupt_request_low = ~int_summary_q;

   // Sticky load-failed flag, cleared only by reset
   // No software clear exists, so no set-versus-clear race arises
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
         config_load_failed_q <= `RST_LOAD_FLAGS;
      else if (load_evt.failed)
         config_load_failed_q <= 1'b1;
   end

   // Sticky load-done flag, cleared only by reset
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
         config_load_done_q <= `RST_LOAD_FLAGS;
      else if (load_evt.done)
         config_load_done_q <= 1'b1;
   end

   // Checksum flag, active low, falls on CRC error and holds until reset
   // The loader retries only after a reset pulse
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
         config_checksum_ok_q <= `RST_CHECKSUM_OK;
      else if (load_evt.crc_error)
         config_checksum_ok_q <= 1'b0;
   end

   // Lockout follows the checksum flag; only the reset pin releases it
   assign serial_port_locked = ~config_checksum_ok_q;

   // Calibration codes registered for stable reads
   // Codes may move every cycle; a read shows the value one edge old
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
      begin
         cal0_q <= '0;
         cal1_q <= '0;
      end
      else
      begin
         cal0_q <= calibration_code_0;
         cal1_q <= calibration_code_1;
      end
   end

   // Decode the read; reserved bits return zero
   // Zero reserved bits give the host a defined value to ignore
   assign {rd_hit, rd_data} = read_mux(req.addr,
                                       level_masked,
                                       int_summary_q, cal0_q, cal1_q,
                                       config_load_failed_q, config_load_done_q,
                                       config_checksum_ok_q);

   // A read is taken on the strobe; a hit needs a mapped address too
   assign rd_take = req.rd;
   assign rd_take_hit = req.rd & rd_hit;

   // Answer valid one cycle after the strobe; no flag is touched by it
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
         rsp_valid_q <= 1'b0;
      else
         rsp_valid_q <= rd_take;
   end

   // Hit marks a mapped address; unmapped reads answer with hit low
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
         rsp_hit_q <= 1'b0;
      else
         rsp_hit_q <= rd_take_hit;
   end

   // Data stands only in the answer cycle and is zero otherwise
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
         rsp_data_q <= `RST_READ_DATA;
      else if (rd_take_hit)
         rsp_data_q <= rd_data;
      else
         rsp_data_q <= `RST_READ_DATA;
   end

   // Answer gathered into its carrier struct
   assign rsp = '{valid: rsp_valid_q, hit: rsp_hit_q, data: rsp_data_q};
endmodule : global_status_registers

// *** sim/status_checker.sv ***
/* Assertions on the status group ports.
 Assumes one clock and an async active-low reset. */
`timescale 1ns/100ps
module status_checker
   import status_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic hardware_reset_low, // Reset
   input wire logic [3:0] gpio_pin_in, // Pins
   input wire logic [3:0] gpio_is_input, // Pin modes
   input wire logic [7:0] int_status, // Status
   input wire logic [7:0] int_enable, // Enables
   input wire load_evt_s load_evt, // Loader events
   input wire logic [5:0] calibration_code_0, // Code
   input wire reg_req_s req, // Request
   input wire reg_rsp_s rsp, // Answer
   input wire logic interrupt_request_low, // Irq pin
   input wire logic serial_port_locked // Lockout
);
   logic [2:0] ev_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!hardware_reset_low);
   // Loader events seen since reset
   always_ff @(posedge clk or negedge hardware_reset_low)
   begin
      if (!hardware_reset_low)
         ev_q <= 3'h0;
      else
         ev_q <= ev_q | load_evt;
   end
   sequence s_rd(logic [15:0] a); req.rd && req.addr == a; endsequence
   sequence s_level; $stable({gpio_pin_in, gpio_is_input})[*7] ##0 s_rd(16'h0219); endsequence
   property p_level; s_level |=> rsp.data == {4'h0, $past(gpio_pin_in & gpio_is_input)};
   endproperty
   a_level: assert property (p_level) else $error("pin level");
   property p_int; $past(hardware_reset_low) |-> interrupt_request_low == !(|$past(int_status & int_enable));
   endproperty
   a_int: assert property (p_int) else $error("irq pin");
   property p_fail; s_rd(16'h021E) && !load_evt.failed |=> rsp.data == {7'h0, ev_q[1]}; endproperty
   a_fail: assert property (p_fail) else $error("failed flag");
   property p_done; s_rd(16'h021F) && load_evt == 3'h0 |=>
      rsp.data == {4'h0, !ev_q[0], 2'h0, ev_q[2]}; endproperty
   a_done: assert property (p_done) else $error("load result");
   property p_lock; load_evt.crc_error || serial_port_locked |=> serial_port_locked; endproperty
   a_lock: assert property (p_lock) else $error("lockout");
   property p_cal; s_rd(16'h021C) && $stable(calibration_code_0) |=>
      rsp.hit && rsp.data == {2'h0, $past(calibration_code_0)}; endproperty
   a_cal: assert property (p_cal) else $error("cal code");
   property p_rsv; s_rd(16'h021B) |=> rsp.valid && rsp.hit && rsp.data == 8'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved");
   property p_side; req.rd && !load_evt.crc_error |=>
      serial_port_locked == $past(serial_port_locked); endproperty
   a_side: assert property (p_side) else $error("read side effect");
endmodule : status_checker
bind global_status_registers status_checker i_chk (.*);

// *** sim/status_host.sv ***
/* Host model issuing one-byte status reads.
 Assumes a read is taken on the rising edge with rd high. */
`timescale 1ns/100ps
module status_host
   import status_pkg::*;
(
   input wire logic clk, // Clock
   input wire reg_rsp_s rsp, // Answer
   output reg_req_s req // Request
);
   initial req = '0;
   // Strobe for one edge, take the answer before the next
   task automatic rd(input logic [15:0] a, output reg_rsp_s r);
      @(negedge clk);
      req = '{rd: 1'b1, addr: a};
      @(negedge clk);
      r = rsp;
      req = '{rd: 1'b0, addr: ~a};
   endtask : rd
endmodule : status_host

// *** sim/tb_top.sv ***
/* Bench for the status group.
 Assumes the host model and the bound checker. */
`timescale 1ns/100ps
module tb_top;
   import status_pkg::*;
   logic clk, hardware_reset_low, irq_low, locked;
   logic [3:0] pin, isin;
   logic [7:0] ist, ien;
   logic [5:0] c0, c1;
   load_evt_s evt;
   reg_req_s req;
   reg_rsp_s rsp, r;
   int bad_count, cmp_count, cyc;
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   global_status_registers i_dut (.clk(clk), .hardware_reset_low(hardware_reset_low), .gpio_pin_in(pin),
      .gpio_is_input(isin), .int_status(ist), .int_enable(ien), .load_evt(evt),
      .calibration_code_0(c0), .calibration_code_1(c1), .req(req), .rsp(rsp),
      .interrupt_request_low(irq_low), .serial_port_locked(locked));
   status_host i_host (.clk(clk), .rsp(rsp), .req(req));
   task chk(input logic [9:0] g, input logic [9:0] e);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task chk_pin(input logic g, input logic e);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_pin
   task rr(input logic [15:0] a, input logic [7:0] d, input logic h);
      i_host.rd(a, r);
      chk(r, {1'b1, h, d});
   endtask : rr
   task rst;
      hardware_reset_low = 1'b0;
      repeat (3) @(negedge clk);
      hardware_reset_low = 1'b1;
   endtask : rst
   task pulse(input logic [2:0] v);
      @(negedge clk);
      evt = v;
      @(negedge clk);
      evt = 3'h0;
   endtask : pulse
   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         bad_count++;
         conclude();
      end
   end
   // Main sequence
   initial
   begin
      {bad_count, cmp_count, cyc} = '0;
      {hardware_reset_low, pin, isin, ist, ien, evt} = {1'b0, 4'hA, 4'h6, 8'h10, 8'h01, 3'h0};
      {c0, c1} = {6'h2A, 6'h15};
      rst();
      repeat (8) @(negedge clk);
      rr(16'h0219, 8'h02, 1'b1);
      rr(16'h021C, 8'h2A, 1'b1);
      rr(16'h021D, 8'h15, 1'b1);
      rr(16'h021B, 8'h00, 1'b1);
      rr(16'h0300, 8'h00, 1'b0);
      rr(16'h021F, 8'h08, 1'b1);
      rr(16'h021A, 8'h00, 1'b1);
      chk_pin(irq_low, 1'b1);
      $display("test static done");
      {pin, c0} = {4'h5, 6'h3F};
      repeat (8) @(negedge clk);
      rr(16'h0219, 8'h04, 1'b1);
      rr(16'h021C, 8'h3F, 1'b1);
      $display("test change done");
      ien = 8'h11;
      rr(16'h021A, 8'h01, 1'b1);
      chk_pin(irq_low, 1'b0);
      $display("test interrupt done");
      pulse(3'h6);
      rr(16'h021E, 8'h01, 1'b1);
      rr(16'h021F, 8'h09, 1'b1);
      rr(16'h021F, 8'h09, 1'b1);
      chk_pin(locked, 1'b0);
      pulse(3'h1);
      rr(16'h021F, 8'h01, 1'b1);
      chk_pin(locked, 1'b1);
      $display("test load done");
      rst();
      chk_pin(locked, 1'b0);
      rr(16'h021E, 8'h00, 1'b1);
      rr(16'h021F, 8'h08, 1'b1);
      $display("test retry done");
      conclude();
   end
endmodule : tb_top
